//--- ddr2_odt_vector_select.sv
// termination vector register and odd chip-select line driver
//
// Notes on behaviour
// R1 - register holds four per-rank read/write nibble bytes
// R2 - rank0 bits 3:0/7:4 up to rank6 31:28
// R3 - dual channel drives same vector on both
// R4 - nibble bits 3..0 drive lines 7,5,3,1
// R5 - set bits asserted, others held deasserted
// R6 - one-to-one mapping holds when map equals 8421h
// R7 - ddr2 mode turns odd selects into termination
// R8 - vector latched at access start, held throughout
`timescale 1ns/10ps
`include "ddr2_odt_map.svh"

module ddr2_odt_vector_select (
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_i,
   // config register port
   input  wire ddr2_odt_pkg::cfg_req_t cfg_i,
   output logic [31:0]                 cfg_rdata_o,
   // mode straps and rank mapping
   input  wire logic                   ddr2_mode_i,
   input  wire logic                   dual_channel_i,
   input  wire logic [15:0]            rank_map_i,
   output logic                        map_identity_o,
   // access control from the command logic
   input  wire logic                   acc_start_i,
   input  wire ddr2_odt_pkg::access_t  acc_i,
   input  wire logic                   acc_end_i,
   // odd chip-select levels used outside ddr2 mode
   input  wire logic [3:0]             cs_odd_i,
   // odd lines of both channels, bit 3 = line 7 .. bit 0 = line 1
   output logic [3:0]                  odd_line_a_o,
   output logic [3:0]                  odd_line_b_o,
   output logic                        access_active_o
);

   ////////////////////////////////////////////////////////////////////////////
   // register file

   logic [31:0]            ctrl;
   logic [31:0]            next_ctrl;
   logic [31:0]            next_rdata;
   logic                   hit;
   logic [`TERM_W-1:0]     rd_vec [`RANK_CNT];
   logic [`TERM_W-1:0]     wr_vec [`RANK_CNT];

   assign hit = (cfg_i.addr[7:2] == 6'(`TVC_OFFSET >> 2));

   // per byte write and nibble split, one byte per rank
   // each byte has its own driver, so partial writes leave the other ranks alone
   genvar g;
   generate
      for (g = 0; g < `RANK_CNT; g++) begin : g_rank
         assign next_ctrl[g*8 +: 8] = (cfg_i.wr && hit && cfg_i.be[g]) ?
                                      cfg_i.wdata[g*8 +: 8] : ctrl[g*8 +: 8]; // R1
         assign rd_vec[g] = ctrl[g*`TVC_BYTE_W+`TVC_RD_LSB +: `TERM_W]; // R2
         assign wr_vec[g] = ctrl[g*`TVC_BYTE_W+`TVC_WR_LSB +: `TERM_W]; // R2
      end
   endgenerate

   // unmapped reads answer zero so probing software sees a hole
   always_comb begin
      next_rdata = cfg_rdata_o;
      if (cfg_i.rd) begin
         next_rdata = hit ? ctrl : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl        <= `TVC_RESET;
         cfg_rdata_o <= 32'h0000_0000;
      end else begin
         ctrl        <= next_ctrl;
         cfg_rdata_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // access tracking and vector hold

   ddr2_odt_pkg::state_t state;
   ddr2_odt_pkg::state_t next_state;
   logic [`TERM_W-1:0]   held;
   logic [`TERM_W-1:0]   next_held;
   logic [`TERM_W-1:0]   sel;

   assign sel = acc_i.write ? wr_vec[acc_i.rank] : rd_vec[acc_i.rank];

   // latching at start keeps a mid-access register write from glitching odt
   always_comb begin
      next_state = state;
      next_held  = held;
      case (state)
         ddr2_odt_pkg::S_IDLE: begin
            if (acc_start_i) begin
               next_state = ddr2_odt_pkg::S_ACTIVE;
               next_held  = sel; // R8
            end
         end
         ddr2_odt_pkg::S_ACTIVE: begin
            if (acc_end_i) begin
               next_state = ddr2_odt_pkg::S_IDLE;
               next_held  = `TERM_OFF;
            end
         end
         default: begin
            next_state = ddr2_odt_pkg::S_IDLE;
            next_held  = `TERM_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ddr2_odt_pkg::S_IDLE;
         held  <= `TERM_OFF;
      end else begin
         state <= next_state;
         held  <= next_held;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // odd line drivers

   logic [3:0] next_line_a;
   logic [3:0] next_line_b;
   logic       next_ident;
   logic       next_active;

   // in ddr2 mode channel b idles off when single channel; no rank there to terminate
   always_comb begin
      next_active = (state == ddr2_odt_pkg::S_ACTIVE);
      next_ident  = (rank_map_i == `RANK_MAP_IDENTITY); // R6
      next_line_a = cs_odd_i;
      next_line_b = cs_odd_i;
      if (ddr2_mode_i) begin // R7
         next_line_a = next_active ? held : `TERM_OFF; // R4 R5
         next_line_b = dual_channel_i ? next_line_a : `TERM_OFF; // R3
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         odd_line_a_o    <= 4'h0;
         odd_line_b_o    <= 4'h0;
         map_identity_o  <= 1'b0;
         access_active_o <= 1'b0;
      end else begin
         odd_line_a_o    <= next_line_a;
         odd_line_b_o    <= next_line_b;
         map_identity_o  <= next_ident;
         access_active_o <= next_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start;
      state == ddr2_odt_pkg::S_IDLE && acc_start_i;
   endsequence

   sequence s_start_r0_rd;
      s_start and (acc_i.rank == 2'd0 && !acc_i.write);
   endsequence

   sequence s_start_r6_wr;
      s_start and (acc_i.rank == 2'd3 && acc_i.write);
   endsequence

   property p_full_write;
      (cfg_i.wr && hit && cfg_i.be == 4'hF) |=> ctrl == $past(cfg_i.wdata);
   endproperty
   a_full_write: assert property (p_full_write) // R1
      else $error("full register write not stored");

   property p_field_low;
      s_start_r0_rd |=> held == $past(ctrl[3:0]);
   endproperty
   a_field_low: assert property (p_field_low) // R2
      else $error("rank0 read nibble misplaced");

   property p_field_high;
      s_start_r6_wr |=> held == $past(ctrl[31:28]);
   endproperty
   a_field_high: assert property (p_field_high) // R2
      else $error("rank6 write nibble misplaced");

   property p_dual;
      (ddr2_mode_i && dual_channel_i) |=> odd_line_b_o == odd_line_a_o;
   endproperty
   a_dual: assert property (p_dual) // R3
      else $error("channels disagree in dual mode");

   property p_bit_map;
      s_start ##1 (ddr2_mode_i && state == ddr2_odt_pkg::S_ACTIVE)
         |=> odd_line_a_o == $past(held, 1) && odd_line_a_o == $past(sel, 2);
   endproperty
   a_bit_map: assert property (p_bit_map) // R4
      else $error("nibble not mapped onto odd lines");

   property p_idle_off;
      (ddr2_mode_i && state == ddr2_odt_pkg::S_IDLE) |=> odd_line_a_o == 4'h0;
   endproperty
   a_idle_off: assert property (p_idle_off) // R5
      else $error("termination driven outside access");

   property p_ident;
      rank_map_i == 16'h8421 |=> map_identity_o;
   endproperty
   a_ident: assert property (p_ident) // R6
      else $error("identity map not flagged");

   property p_cs_pass;
      !ddr2_mode_i |=> odd_line_a_o == $past(cs_odd_i);
   endproperty
   a_cs_pass: assert property (p_cs_pass) // R7
      else $error("odd lines not chip select outside ddr2");

   property p_hold;
      (state == ddr2_odt_pkg::S_ACTIVE && !acc_end_i) |=> $stable(held);
   endproperty
   a_hold: assert property (p_hold) // R8
      else $error("vector changed during access");

endmodule : ddr2_odt_vector_select

//--- ddr2_odt_map.svh
// offsets, field positions, reset values and constants of the termination vector select
`ifndef DDR2_ODT_MAP_SVH
`define DDR2_ODT_MAP_SVH
`define TVC_OFFSET        8'hB0
`define TVC_RESET         32'h0000_0000
`define TVC_BYTE_W        8
`define TVC_RD_LSB        0
`define TVC_WR_LSB        4
`define TERM_W            4
`define RANK_CNT          4
`define RANK_MAP_IDENTITY 16'h8421
`define TERM_OFF          4'h0
`endif

//--- ddr2_odt_pkg.sv
// types shared by the termination vector select
package ddr2_odt_pkg;
   // one access as issued by the command logic
   typedef struct packed {
      logic       write;  // 1 = write access, 0 = read access
      logic [1:0] rank;   // logical chip-select 0,2,4,6 as index 0..3
   } access_t;
   // config register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_t;
   typedef enum logic [1:0] {
      S_IDLE   = 2'b00,
      S_ACTIVE = 2'b01
   } state_t;
endpackage : ddr2_odt_pkg

//--- ddr2_rank_model.sv
// behavioural ranks: the termination level each rank sees on both channels
`timescale 1ns/10ps

module ddr2_rank_model (
   // clock and odd lines of both channels
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] odd_line_a_i,
   input  wire logic [3:0] odd_line_b_i,
   // lines 7,5,3,1 of channel b then channel a, as last sampled
   output logic [7:0]      term_seen_o
);
   // ranks only sample the lines, they never drive them back
   always_ff @(posedge sys_clk_i) begin
      term_seen_o <= {odd_line_b_i, odd_line_a_i};
   end
endmodule : ddr2_rank_model

//--- tb_top.sv
// self-checking bench for the termination vector select
`timescale 1ns/10ps
`include "ddr2_odt_map.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module tb_top;
   logic                   sys_clk_i = 1'b0;
   logic                   rst_i     = 1'b1;
   ddr2_odt_pkg::cfg_req_t cfg_i     = '0;
   ddr2_odt_pkg::access_t  acc_i     = '0;
   logic                   ddr2      = 1'b1;
   logic                   dual      = 1'b1;
   logic                   st        = 1'b0;
   logic                   en        = 1'b0;
   logic [15:0]            map       = 16'h0000;
   logic [3:0]             cs        = 4'h0;
   logic [31:0]            rdata;
   logic [3:0]             la, lb;
   logic [7:0]             seen;
   logic                   ident, act;
   int                     miscompares = 0;
   int                     tests_run   = 0;
   localparam logic [31:0] regv        = 32'h8E5C_36A1;

   // free-running 25 MHz clock
   always #20 sys_clk_i = ~sys_clk_i;

   ddr2_odt_vector_select u_dut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .cfg_rdata_o(rdata),
      .ddr2_mode_i(ddr2), .dual_channel_i(dual), .rank_map_i(map),
      .map_identity_o(ident), .acc_start_i(st), .acc_i(acc_i), .acc_end_i(en),
      .cs_odd_i(cs), .odd_line_a_o(la), .odd_line_b_o(lb), .access_active_o(act));

   ddr2_rank_model u_rank (.sys_clk_i(sys_clk_i), .odd_line_a_i(la),
      .odd_line_b_i(lb), .term_seen_o(seen));

   ////////////////////////////////////////////////////////////////////////////
   // inputs move 1 ns after the edge so no race with the sampling edge
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : cyc

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // request stands for one edge, then one idle edge before the next transfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      cfg_i = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
      cyc(1);
      cfg_i = '0;
      cyc(1);
   endtask : wr

   // read data is held after the cycle that takes the read
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      cfg_i = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0000_0000};
      cyc(1);
      cfg_i = '0;
      cyc(1);
      `CHK(rdata, e);
   endtask : rd

   // one access; a second start and a register write in mid-transfer are ignored
   task automatic access(input int r, input logic w, input logic [3:0] ea, eb);
      acc_i = '{write: w, rank: 2'(r)};
      st    = 1'b1;
      cyc(1);
      st = 1'b0;
      cyc(2);
      `CHK(la, ea);
      `CHK(lb, eb);
      `CHK(act, 1'b1);
      acc_i = '{write: !w, rank: 2'(r + 1)};
      st    = 1'b1;
      cyc(1);
      st = 1'b0;
      wr(`TVC_OFFSET, ~regv, 4'hF);
      cyc(2);
      `CHK(la, ea);
      `CHK(seen, {eb, ea});
      en = 1'b1;
      cyc(1);
      en = 1'b0;
      cyc(2);
      `CHK({lb, la}, 8'h00);
      `CHK(act, 1'b0);
      wr(`TVC_OFFSET, regv, 4'hF);
   endtask : access

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_regs();
      rd(`TVC_OFFSET, `TVC_RESET);
      wr(`TVC_OFFSET, regv, 4'hF);
      rd(`TVC_OFFSET, regv);
      wr(8'hB4, 32'hFFFF_FFFF, 4'hF);
      rd(`TVC_OFFSET, regv);
      wr(`TVC_OFFSET, 32'h1234_5678, 4'h2);
      rd(8'hB3, {regv[31:16], 8'h56, regv[7:0]});
      rd(8'hB4, 32'h0000_0000);
      // read and write in one cycle: the read returns the old contents
      cfg_i = '{wr: 1'b1, rd: 1'b1, addr: `TVC_OFFSET, be: 4'hF, wdata: regv};
      cyc(1);
      cfg_i = '0;
      cyc(1);
      `CHK(rdata, {regv[31:16], 8'h56, regv[7:0]});
      rd(`TVC_OFFSET, regv);
      $display("test regs done");
   endtask : test_regs

   // reset in mid-access clears the lines and the register
   task automatic test_reset();
      acc_i = '{write: 1'b1, rank: 2'd0};
      st    = 1'b1;
      cyc(1);
      st = 1'b0;
      cyc(2);
      `CHK(la, regv[7:4]);
      rst_i = 1'b1;
      cyc(2);
      `CHK({lb, la}, 8'h00);
      `CHK(act, 1'b0);
      rst_i = 1'b0;
      cyc(1);
      rd(`TVC_OFFSET, `TVC_RESET);
      wr(`TVC_OFFSET, regv, 4'hF);
      $display("test reset done");
   endtask : test_reset

   // every rank in both directions, then single channel
   task automatic test_access();
      for (int r = 0; r < 4; r++) begin
         for (int w = 0; w < 2; w++) begin
            access(r, w[0], regv[r*8+w*4 +: 4], regv[r*8+w*4 +: 4]);
         end
      end
      dual = 1'b0;
      access(2, 1'b1, regv[23:20], 4'h0);
      dual = 1'b1;
      $display("test access done");
   endtask : test_access

   task automatic test_modes();
      map = `RANK_MAP_IDENTITY;
      cyc(1);
      `CHK(ident, 1'b1);
      map = 16'h8420;
      cyc(1);
      `CHK(ident, 1'b0);
      ddr2 = 1'b0;
      cs   = 4'hA;
      cyc(1);
      `CHK({lb, la}, 8'hAA);
      $display("test modes done");
   endtask : test_modes

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // reset for six cycles, then the scenarios in turn
   initial begin
      repeat (6) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      cyc(1);
      test_regs();
      test_access();
      test_reset();
      test_modes();
      final_report();
   end
endmodule : tb_top
